// ### hdl/adcrw_cfg.svh
// adcrw_cfg.svh - named constants of the converter readout and watchdog block
// assumes: included by bare name wherever a constant is needed
`ifndef ADCRW_CFG_SVH
`define ADCRW_CFG_SVH

// clock rates
`define ADCRW_CLK_KHZ 100000
`define ADCRW_CONV_KHZ 1000
`define ADCRW_DIV_CYCLES (`ADCRW_CLK_KHZ / `ADCRW_CONV_KHZ)
`define ADCRW_DIV_W 7

// watchdog timeout in ms and its cycle count (exact product, nothing rounds)
`define ADCRW_WDOG_MS 10200
`define ADCRW_WDOG_CYCLES ((64'd`ADCRW_WDOG_MS * 64'd`ADCRW_CLK_KHZ))
`define ADCRW_WDOG_W 32

// processor reset pulse length in us, counted in 1 MHz ticks
`define ADCRW_RST_US 100
`define ADCRW_RST_TICKS ((`ADCRW_RST_US * `ADCRW_CONV_KHZ) / 1000)

// conversion time per channel in us, counted in 1 MHz ticks
`define ADCRW_CONV_US 100
`define ADCRW_CONV_TICKS ((`ADCRW_CONV_US * `ADCRW_CONV_KHZ) / 1000)
`define ADCRW_TICK_W 16

// address decode: A15..A9 all one, A8..A5 = 0,1,1,0
`define ADCRW_HI_MSB 15
`define ADCRW_HI_LSB 9
`define ADCRW_HI_MATCH 7'h7f
`define ADCRW_MID_MSB 8
`define ADCRW_MID_LSB 5
`define ADCRW_MID_MATCH 4'h6
`define ADCRW_CONV_MSB 4
`define ADCRW_CONV_LSB 3
`define ADCRW_CH_MSB 2
`define ADCRW_CH_LSB 0

// sizes
`define ADCRW_NCONV 4
`define ADCRW_NCH 8
`define ADCRW_DW 8

`endif

// ### hdl/adcrw_pkg.sv
// adcrw_pkg.sv - types of the converter readout and watchdog block
// assumes: adcrw_cfg.svh gives the sizes
`include "adcrw_cfg.svh"

package adcrw_pkg;

  // watchdog states
  typedef enum logic [0:0] {ADCRW_WD_RUN, ADCRW_WD_RESET} adcrw_wd_t;

  // converter state: channel pointer, tick count, result store, sampler
  typedef struct packed {
    logic [`ADCRW_DW-1:0] samp_s1;
    logic [`ADCRW_DW-1:0] samp_s2;
    logic [`ADCRW_TICK_W-1:0] tick_cnt;
    logic [2:0] chan;
    logic [`ADCRW_NCH-1:0][`ADCRW_DW-1:0] store;
  } adcrw_conv_st_t;

  // top state: pin synchronisers, divider, watchdog, bus outputs
  typedef struct packed {
    logic [15:0] addr_s1;
    logic [15:0] addr_s2;
    logic [2:0] ctl_s1;
    logic [2:0] ctl_s2;
    logic [`ADCRW_DIV_W-1:0] div_cnt;
    logic tick;
    adcrw_wd_t wd;
    logic [`ADCRW_WDOG_W-1:0] wd_cnt;
    logic [`ADCRW_TICK_W-1:0] rst_cnt;
    logic [`ADCRW_DW-1:0] di;
    logic di_oe;
    logic [`ADCRW_NCONV-1:0] en_n;
    logic rst_oe;
  } adcrw_top_st_t;

endpackage : adcrw_pkg

// ### hdl/adcrw_conv.sv
// adcrw_conv.sv - one converter: channel scan and eight-word result store
// assumes: tick is a one-cycle 1 MHz enable; samp_code comes from a pin
`timescale 1ns/10ps
`include "adcrw_cfg.svh"

module adcrw_conv
  import adcrw_pkg::*;
#(
  parameter int CONV_TICKS = `ADCRW_CONV_TICKS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // conversion timing
  input wire logic tick,
  // front end
  input wire logic [`ADCRW_DW-1:0] samp_code,
  output logic [2:0] mux_chan,
  // read port
  input wire logic [2:0] rd_chan,
  output logic [`ADCRW_DW-1:0] rd_data
);

  initial
  begin
    if (CONV_TICKS < 1 || CONV_TICKS >= (1 << `ADCRW_TICK_W))
      $error("adcrw_conv: CONV_TICKS out of range");
  end

  adcrw_conv_st_t st_reg, st_next;

  ////////////////////////////////////////////////////////////////////////////
  // scan channels in turn, one conversion per CONV_TICKS ticks
  always_comb
  begin
    st_next = st_reg;
    st_next.samp_s1 = samp_code;
    st_next.samp_s2 = st_reg.samp_s1;
    if (tick) // paced by the shared 1 MHz enable
    begin
      if (st_reg.tick_cnt == `ADCRW_TICK_W'(CONV_TICKS - 1))
      begin
        st_next.tick_cnt = '0;
        st_next.store[st_reg.chan] = st_reg.samp_s2; // latest result kept
        st_next.chan = st_reg.chan + 3'h1; // next channel, wraps at eight
      end
      else
        st_next.tick_cnt = st_reg.tick_cnt + `ADCRW_TICK_W'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // outputs
  assign mux_chan = st_reg.chan;
  assign rd_data = st_reg.store[rd_chan]; // three low address bits pick a word

endmodule : adcrw_conv

// ### hdl/adcrw_top.sv
// adcrw_top.sv - bus readout of four converters with access watchdog
// assumes: bus pins are asynchronous to sys_clk; reset line is open drain
`timescale 1ns/10ps
`include "adcrw_cfg.svh"

// Function
// - Each converter scans its eight channels in turn and keeps the latest eight-bit results in an 8x8 store.
// - All conversion sequencing runs from one shared 1 MHz enable made on the board.
// - Address bits A2..A0 pick which of the eight stored results is returned.
// - The board is selected only for A15..A9 all one, A8=0, A7=1, A6=1, A5=0 with memory-read status high.
// - While selected, A4..A3 assert exactly one active-low converter enable.
// - Read data drives the data-in bus only while selected and data-bus-in timing is high.
// - Every select outside a reset pulse restarts a watchdog; 10.2 s without one asserts processor reset.
// - On expiry the board pulls the active-low shared processor reset line low.
module adcrw_top
  import adcrw_pkg::*;
#(
  parameter longint WDOG_CYCLES = `ADCRW_WDOG_CYCLES,
  parameter int RST_TICKS = `ADCRW_RST_TICKS,
  parameter int CONV_TICKS = `ADCRW_CONV_TICKS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // backplane address and status
  input wire logic [15:0] addr,
  input wire logic smemr,
  input wire logic pdbin,
  input wire logic mwrite,
  // backplane data-in bus
  output logic [`ADCRW_DW-1:0] di_o,
  output logic di_oe,
  // shared processor reset line, open drain
  input wire logic cpu_rst_n_i,
  output logic cpu_rst_n_o,
  output logic cpu_rst_n_oe,
  // converter enables
  output logic [`ADCRW_NCONV-1:0] conv_en_n,
  // analog front end
  input wire logic [`ADCRW_NCONV*`ADCRW_DW-1:0] samp_code,
  output logic [`ADCRW_NCONV*3-1:0] mux_chan
);

  initial
  begin
    if (WDOG_CYCLES < 2 || WDOG_CYCLES >= (64'h1 << `ADCRW_WDOG_W))
      $error("adcrw_top: WDOG_CYCLES out of range");
    if (RST_TICKS < 1 || RST_TICKS >= (1 << `ADCRW_TICK_W))
      $error("adcrw_top: RST_TICKS out of range");
    if (`ADCRW_DIV_CYCLES >= (1 << `ADCRW_DIV_W))
      $error("adcrw_top: divider width too small");
  end

  localparam logic [`ADCRW_WDOG_W-1:0] WD_LAST = `ADCRW_WDOG_W'(WDOG_CYCLES - 1);
  localparam logic [`ADCRW_TICK_W-1:0] RST_LAST = `ADCRW_TICK_W'(RST_TICKS - 1);
  localparam logic [`ADCRW_DIV_W-1:0] DIV_LAST = `ADCRW_DIV_W'(`ADCRW_DIV_CYCLES - 1);

  adcrw_top_st_t st_reg, st_next;
  logic [`ADCRW_NCONV-1:0][`ADCRW_DW-1:0] rd_data;
  logic [2:0] rd_chan;
  logic [1:0] conv_idx;
  logic [`ADCRW_HI_MSB-`ADCRW_HI_LSB:0] addr_hi;
  logic [`ADCRW_MID_MSB-`ADCRW_MID_LSB:0] addr_mid;
  logic smemr_s;
  logic pdbin_s;
  logic mwrite_s;
  logic board_sel;
  logic unused_rst_in;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised fields of the bus
  assign smemr_s = st_reg.ctl_s2[2];
  assign pdbin_s = st_reg.ctl_s2[1];
  assign mwrite_s = st_reg.ctl_s2[0];
  assign addr_hi = st_reg.addr_s2[`ADCRW_HI_MSB:`ADCRW_HI_LSB];
  assign addr_mid = st_reg.addr_s2[`ADCRW_MID_MSB:`ADCRW_MID_LSB];
  assign rd_chan = st_reg.addr_s2[`ADCRW_CH_MSB:`ADCRW_CH_LSB];
  assign conv_idx = st_reg.addr_s2[`ADCRW_CONV_MSB:`ADCRW_CONV_LSB];

  // board select decode
  assign board_sel = (addr_hi == `ADCRW_HI_MATCH)
                   && (addr_mid == `ADCRW_MID_MATCH)
                   && smemr_s; // A15..A5 pattern with memory read

  // the reset line is only driven, never sensed
  assign unused_rst_in = cpu_rst_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // four converters, one per enable
  genvar gi;
  generate
    for (gi = 0; gi < `ADCRW_NCONV; gi++)
    begin : g_conv
      adcrw_conv #(
        .CONV_TICKS(CONV_TICKS)
      ) u_conv (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(st_reg.tick),
        .samp_code(samp_code[gi*`ADCRW_DW +: `ADCRW_DW]),
        .mux_chan(mux_chan[gi*3 +: 3]),
        .rd_chan(rd_chan),
        .rd_data(rd_data[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    st_next = st_reg;

    // two-stage pin synchronisers
    st_next.addr_s1 = addr;
    st_next.addr_s2 = st_reg.addr_s1;
    st_next.ctl_s1 = {smemr, pdbin, mwrite};
    st_next.ctl_s2 = st_reg.ctl_s1;

    // 1 MHz conversion enable from the system clock
    st_next.tick = 1'b0;
    if (st_reg.div_cnt == DIV_LAST)
    begin
      st_next.div_cnt = '0;
      st_next.tick = 1'b1; // shared by every converter
    end
    else
      st_next.div_cnt = st_reg.div_cnt + `ADCRW_DIV_W'(1);

    // one-hot active-low converter enable while selected
    st_next.en_n = '1;
    if (board_sel)
      st_next.en_n[conv_idx] = 1'b0; // A4..A3 choose one converter

    // data-in drive, reads only
    st_next.di_oe = board_sel && pdbin_s && !mwrite_s;
    st_next.di = st_next.di_oe ? rd_data[conv_idx] : '0;

    // watchdog: each select while running restarts it, expiry pulses processor reset
    unique case (st_reg.wd)
      ADCRW_WD_RUN:
      begin
        if (board_sel)
          st_next.wd_cnt = '0; // select restarts the timer
        else if (st_reg.wd_cnt == WD_LAST)
        begin
          st_next.wd = ADCRW_WD_RESET; // expiry after 10.2 s
          st_next.wd_cnt = '0;
          st_next.rst_cnt = '0;
          st_next.rst_oe = 1'b1; // pull the reset line low
        end
        else
          st_next.wd_cnt = st_reg.wd_cnt + `ADCRW_WDOG_W'(1);
      end
      ADCRW_WD_RESET:
      begin
        if (st_reg.tick)
        begin
          if (st_reg.rst_cnt == RST_LAST)
          begin
            st_next.wd = ADCRW_WD_RUN;
            st_next.rst_oe = 1'b0; // release and time afresh
            st_next.wd_cnt = '0;
          end
          else
            st_next.rst_cnt = st_reg.rst_cnt + `ADCRW_TICK_W'(1);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.wd <= ADCRW_WD_RUN;
      st_reg.en_n <= '1;
    end
    else
      st_reg <= st_next;
  end

  // outputs, all from the state register
  assign di_o = st_reg.di;
  assign di_oe = st_reg.di_oe;
  assign conv_en_n = st_reg.en_n;
  assign cpu_rst_n_oe = st_reg.rst_oe;
  assign cpu_rst_n_o = ~st_reg.rst_oe; // line low whenever driven

endmodule : adcrw_top

// ### sim/adcrw_top_checker.sv
// adcrw_top_checker.sv - port assertions of the readout and watchdog block
// assumes: bound into adcrw_top; bus pins change just after clock edges
`timescale 1ns/10ps
module adcrw_top_checker #(
  parameter longint WDOG_CYCLES = 200
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // backplane
  input wire logic [15:0] addr,
  input wire logic smemr,
  input wire logic pdbin,
  input wire logic mwrite,
  input wire logic [7:0] di_o,
  input wire logic di_oe,
  // reset line
  input wire logic cpu_rst_n_i,
  input wire logic cpu_rst_n_o,
  input wire logic cpu_rst_n_oe,
  // converters
  input wire logic [3:0] conv_en_n,
  input wire logic [31:0] samp_code,
  input wire logic [11:0] mux_chan
);
  logic sel;
  logic [31:0] idle_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // board select as seen at the pins
  assign sel = (addr[15:9] == 7'h7f) && (addr[8:5] == 4'h6) && smemr;
  // cycles since the last select or the end of a reset pulse
  always_ff @(posedge sys_clk)
    if (srst || sel || cpu_rst_n_oe) idle_cnt <= 32'h0;
    else idle_cnt <= idle_cnt + 32'h1;
  // a read request and its answer three edges on
  sequence s_rd_req;
    sel && pdbin && !mwrite;
  endsequence
  sequence s_rd_ans;
    ##3 di_oe;
  endsequence
  a_rd_drive: assert property (s_rd_req |-> s_rd_ans)
    else $error("read not driven");
  a_no_drive: assert property (di_oe |-> $past(sel && pdbin && !mwrite, 3))
    else $error("data driven without read");
  a_en_onehot: assert property (conv_en_n != 4'hf |-> $onehot(~conv_en_n))
    else $error("enables not one-hot");
  a_en_decode: assert property (conv_en_n != 4'hf |->
    $past(sel, 3) && conv_en_n == ~(4'h1 << $past(addr[4:3], 3)))
    else $error("wrong converter enable");
  a_sel_enable: assert property (sel && !mwrite |-> ##3 conv_en_n != 4'hf)
    else $error("select gave no enable");
  a_rst_pair: assert property (cpu_rst_n_oe |-> !cpu_rst_n_o)
    else $error("reset line not pulled low");
  a_wd_early: assert property ($rose(cpu_rst_n_oe) |-> $past(idle_cnt) >= WDOG_CYCLES - 4)
    else $error("watchdog fired early");
  a_wd_late: assert property (!cpu_rst_n_oe |-> idle_cnt < WDOG_CYCLES + 6)
    else $error("watchdog fired late");
endmodule : adcrw_top_checker

bind adcrw_top adcrw_top_checker #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (.sys_clk(sys_clk),
  .srst(srst), .addr(addr), .smemr(smemr), .pdbin(pdbin), .mwrite(mwrite), .di_o(di_o),
  .di_oe(di_oe), .cpu_rst_n_i(cpu_rst_n_i), .cpu_rst_n_o(cpu_rst_n_o),
  .cpu_rst_n_oe(cpu_rst_n_oe), .conv_en_n(conv_en_n), .samp_code(samp_code),
  .mux_chan(mux_chan));

// ### sim/adcrw_host_model.sv
// adcrw_host_model.sv - backplane host reading the converter memory
// assumes: bench calls cyc for each access and idle between them
`timescale 1ns/10ps
module adcrw_host_model (
  // clock
  input wire logic sys_clk,
  // backplane outputs
  output logic [15:0] addr,
  output logic smemr,
  output logic pdbin,
  output logic mwrite
);
  // bus idle at time zero
  initial
  begin
    addr = 16'h0;
    smemr = 1'b0;
    pdbin = 1'b0;
    mwrite = 1'b0;
  end
  // hold one access four edges so the answer settles; addresses the board often
  task cyc(input logic [15:0] a, input logic sm, input logic pd, input logic wr);
    @(posedge sys_clk);
    addr <= a;
    smemr <= sm;
    pdbin <= pd;
    mwrite <= wr;
    repeat (4) @(posedge sys_clk);
  endtask : cyc
  // release: address lines show the inverse of the last value
  task idle();
    @(posedge sys_clk);
    addr <= ~addr;
    smemr <= 1'b0;
    pdbin <= 1'b0;
    mwrite <= 1'b0;
  endtask : idle
endmodule : adcrw_host_model

// ### sim/adcrw_top_tb.sv
// adcrw_top_tb.sv - self-checking bench of the readout and watchdog block
// assumes: host model drives the backplane, bench feeds the front end
`timescale 1ns/10ps
module adcrw_top_tb;
  logic sys_clk;
  logic srst;
  logic [15:0] addr;
  logic smemr, pdbin, mwrite, di_oe, rst_o, rst_oe, s, p, w;
  logic [7:0] di_o;
  logic [3:0] en_n;
  logic [31:0] samp;
  logic [11:0] mux;
  logic [7:0] tbl [32];
  logic [15:0] a;
  int seed = 55;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t;
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  adcrw_top #(.WDOG_CYCLES(200), .RST_TICKS(2), .CONV_TICKS(1)) DUT (.sys_clk(sys_clk),
    .srst(srst), .addr(addr), .smemr(smemr), .pdbin(pdbin), .mwrite(mwrite), .di_o(di_o),
    .di_oe(di_oe), .cpu_rst_n_i(~rst_oe), .cpu_rst_n_o(rst_o), .cpu_rst_n_oe(rst_oe),
    .conv_en_n(en_n), .samp_code(samp), .mux_chan(mux));
  adcrw_host_model u_host (.sys_clk(sys_clk), .addr(addr), .smemr(smemr), .pdbin(pdbin),
    .mwrite(mwrite));
  // front end: each converter sees a fixed code per scanned channel
  always @(posedge sys_clk)
    for (int k = 0; k < 4; k++)
      samp[8*k +: 8] <= tbl[{k[1:0], mux[3*k +: 3]}];
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // enable pattern expected for one bus state
  function automatic logic [3:0] exp_en(input logic [15:0] x, input logic sm);
    if (x[15:5] == 11'h7f6 && sm) return ~(4'h1 << x[4:3]);
    return 4'hf;
  endfunction : exp_en
  // one host access and the checks on its answer
  task xfer(input logic [15:0] x, input logic sm, input logic pd, input logic wr);
    logic de;
    u_host.cyc(x, sm, pd, wr);
    #1;
    de = (exp_en(x, sm) != 4'hf) && pd && !wr;
    chk(en_n, exp_en(x, sm));
    chk(di_oe, de);
    chk(di_o, de ? tbl[x[4:0]] : 8'h0);
    u_host.idle();
  endtask : xfer
  // wait for the reset line enable to reach a level, counting cycles
  task wait_oe(input logic lvl);
    t = 0;
    while (rst_oe !== lvl && t < 400)
    begin
      @(posedge sys_clk);
      #1;
      t++;
    end
  endtask : wait_oe
  // main sequence
  initial
  begin
    srst = 1'b1;
    for (int i = 0; i < 32; i++) tbl[i] = 8'($random(seed));
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk({mux, en_n, di_oe, rst_oe, rst_o}, 19'h79);
    repeat (1000) @(posedge sys_clk);
    for (int i = 0; i < 32; i++) xfer(16'hfec0 | 16'(i), 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 60; i++)
    begin
      a = 16'hfec0 | 16'($random(seed) & 31);
      if (i % 2 == 1) a = a ^ (16'h20 << ($unsigned($random(seed)) % 11));
      {s, p, w} = 3'($random(seed));
      xfer(a, s, p, w);
    end
    xfer(16'hfed8, 1'b1, 1'b0, 1'b0);
    wait_oe(1'b1);
    chk(t > 190 && t < 215, 1);
    chk(rst_o, 1'b0);
    wait_oe(1'b0);
    chk(t >= 99 && t <= 205, 1);
    for (int i = 0; i < 3; i++)
    begin
      xfer(16'hfecf, 1'b1, 1'b1, 1'b0);
      repeat (150) @(posedge sys_clk);
      chk(rst_oe, 1'b0);
    end
    stop_test();
  end
endmodule : adcrw_top_tb
